//--- src/mrs_pkg.sv
// Function
// - Station number is 1..63 from switches or 1..127 from software setting.
// - Software station number is used only when all six switches are off.
// - Line-rate codes: 1041=9600, 520=19200, 259=38400, 86=115200; default 520.
// - New station or line-rate settings apply only after save and restart; the code also applies them on the initialize action (save control 2).
// - Save control: 1 commits to storage, 2 initializes updated parameters.
// - Characters are 8 data bits, 1 stop bit, no parity, fixed.
// - Every frame carries a CRC that the receiver checks before acting.
// - A silence of at least 3.5 character times marks a frame boundary.
// - A gap over 1.5 characters inside a frame makes it incomplete; discard.
// - Transmitter sends all characters of a frame back to back.
// - Read reply: station, 03, byte count, register values high first, CRC.
// - A successful single write is answered with a reply frame.
// - Multiple write reply: station, 10, start address, quantity, CRC.
// - Drive objects are scattered holding registers, readable and writable; the code refuses writes to the status word with error 04.
// - Status word is readable at register 0x3200.
// - Control word is writable at register 0x3100.
// - Failed request reply: station, function plus 0x80, error code, CRC.
// - Errors: 01 function, 02 address, 03 data or count, 04 write refused.
package mrs_pkg;
  // Clock and line timing
  localparam int CLK_HZ = 125_000_000;
  localparam int CHAR_BITS = 11;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_19200 = 19200;
  localparam int BAUD_38400 = 38400;
  localparam int BAUD_115200 = 115200;
  localparam logic [15:0] BIT_CYC_9600 = 16'(CLK_HZ / BAUD_9600);
  localparam logic [15:0] BIT_CYC_19200 = 16'(CLK_HZ / BAUD_19200);
  localparam logic [15:0] BIT_CYC_38400 = 16'(CLK_HZ / BAUD_38400);
  localparam logic [15:0] BIT_CYC_115200 = 16'(CLK_HZ / BAUD_115200);
  // Gaps in half-bit units: 1.5 and 3.5 characters
  localparam logic [7:0] GAP_BREAK_HALF = 8'(3 * CHAR_BITS);
  localparam logic [7:0] GAP_END_HALF = 8'(7 * CHAR_BITS);

  // Line-rate codes
  localparam logic [15:0] RATE_9600 = 16'h0411;
  localparam logic [15:0] RATE_19200 = 16'h0208;
  localparam logic [15:0] RATE_38400 = 16'h0103;
  localparam logic [15:0] RATE_115200 = 16'h0056;

  // Holding register addresses
  localparam logic [15:0] ADDR_STATION = 16'h0600;
  localparam logic [15:0] ADDR_LINE_RATE = 16'h2400;
  localparam logic [15:0] ADDR_SOFT_STATION = 16'h2800;
  localparam logic [15:0] ADDR_SAVE = 16'h2910;
  localparam logic [15:0] ADDR_CONTROL = 16'h3100;
  localparam logic [15:0] ADDR_STATUS = 16'h3200;

  // Reset values and station number limits
  localparam logic [7:0] STATION_RST = 8'h01;
  localparam logic [15:0] LINE_RATE_RST = 16'h0208;
  localparam logic [7:0] SOFT_STATION_RST = 8'h7f;
  localparam logic [7:0] SAVE_RST = 8'h01;
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [15:0] STATION_MIN = 16'h0001;
  localparam logic [15:0] STATION_MAX = 16'h007f;

  // Save actions
  localparam logic [15:0] SAVE_STORE = 16'h0001;
  localparam logic [15:0] SAVE_INIT = 16'h0002;

  // Function and error codes
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE1 = 8'h06;
  localparam logic [7:0] FC_WRITEN = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] ERR_FUNCTION = 8'h01;
  localparam logic [7:0] ERR_ADDRESS = 8'h02;
  localparam logic [7:0] ERR_DATA = 8'h03;
  localparam logic [7:0] ERR_WRITE = 8'h04;

  // CRC
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_INIT = 16'hffff;

  localparam int SW_WIDTH = 6;

  typedef struct packed {
    logic en;
    logic [15:0] addr;
    logic [15:0] data;
  } mrs_wr_t;

  typedef enum logic [2:0] {
    S_LOAD,
    S_RX,
    S_PARSE,
    S_CHECK,
    S_EXEC,
    S_TX
  } mrs_state_t;
endpackage

//--- src/mrs_crc16.sv
`timescale 1ns/1ns
`default_nettype none
module mrs_crc16 import mrs_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic enable,
  input wire logic [7:0] dataByte,
  output logic [15:0] crc
);
  logic [15:0] next_crc;

  // One byte through the reflected polynomial
  always_comb begin
    next_crc = crc ^ {8'h00, dataByte};
    for (int i = 0; i < 8; i++) begin
      next_crc = next_crc[0] ? ((next_crc >> 1) ^ CRC_POLY) : (next_crc >> 1);
    end
  end

  // Accumulator, restarts at all ones
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      crc <= CRC_INIT;
    end else if (clear) begin
      crc <= CRC_INIT;
    end else if (enable) begin
      crc <= next_crc;
    end
  end
endmodule
`default_nettype wire

//--- src/mrs_modbus_slave_port.sv
`timescale 1ns/1ns
`default_nettype none
module mrs_modbus_slave_port import mrs_pkg::*; #(
  parameter int CLK_FREQ = CLK_HZ,
  parameter int MAX_READ_REGS = 125,
  parameter int MAX_WRITE_REGS = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rxPin,
  output logic txPin,
  output logic txEnable,
  input wire logic [SW_WIDTH-1:0] idSelectSwitches,
  input wire logic [15:0] deviceStatus,
  output logic [15:0] controlWord,
  output logic controlStrobe,
  output logic storeRequest,
  output logic initRequest,
  output logic [6:0] activeStation
);
  localparam int FRAME_MAX = 9 + 2 * MAX_WRITE_REGS;
  localparam int IW = $clog2(FRAME_MAX + 1);
  localparam logic [IW-1:0] FRAME_LAST = IW'(FRAME_MAX);
  // Bit times follow the clock actually fitted
  localparam logic [15:0] CYC_9600 = 16'(CLK_FREQ / BAUD_9600);
  localparam logic [15:0] CYC_19200 = 16'(CLK_FREQ / BAUD_19200);
  localparam logic [15:0] CYC_38400 = 16'(CLK_FREQ / BAUD_38400);
  localparam logic [15:0] CYC_115200 = 16'(CLK_FREQ / BAUD_115200);

  logic rxMeta;
  logic rxSync;
  logic [SW_WIDTH-1:0] swMeta;
  logic [SW_WIDTH-1:0] swSync;
  mrs_state_t state;
  logic loaded;
  logic [1:0] startCnt;
  logic initPending;
  logic [15:0] bitCyc;
  logic [7:0] stationNumber;
  logic [15:0] lineRate;
  logic [7:0] softStation;
  logic [7:0] saveControl;
  logic rxBusy;
  logic [15:0] rxCnt;
  logic [3:0] rxBit;
  logic [7:0] rxShift;
  logic byteValid;
  logic byteErr;
  logic [15:0] halfCnt;
  logic [7:0] gapHalf;
  logic [7:0] lastGap;
  logic [7:0] rxBuf [FRAME_MAX];
  logic [IW-1:0] rxLen;
  logic rxBad;
  logic [15:0] rxCrc;
  logic frameEnd;
  logic [7:0] opFc;
  logic [15:0] opAddr;
  logic [7:0] opCount;
  logic [7:0] opIdx;
  logic opLast;
  logic isErr;
  logic [7:0] errCode;
  logic [15:0] curAddr;
  logic [15:0] wordIn;
  logic [15:0] lookAddr;
  logic [16:0] lookWord;
  logic [7:0] rdOff;
  logic [7:0] bodyLen;
  logic [7:0] totalLen;
  logic [7:0] txIdx;
  logic [3:0] txBits;
  logic [15:0] txCnt;
  logic [8:0] txShift;
  logic [7:0] txByte;
  logic txLoad;
  logic txDone;
  logic [15:0] txCrc;
  mrs_wr_t wr;

  // Line-rate code to clock cycles per bit
  function automatic logic [15:0] bitCycles(input logic [15:0] code);
    case (code)
      RATE_9600: bitCycles = CYC_9600;
      RATE_38400: bitCycles = CYC_38400;
      RATE_115200: bitCycles = CYC_115200;
      default: bitCycles = CYC_19200;
    endcase
  endfunction

  // Holding register read map: hit flag and value
  function automatic logic [16:0] regRead(input logic [15:0] a);
    case (a)
      ADDR_STATION: regRead = {1'b1, 8'h00, stationNumber};
      ADDR_LINE_RATE: regRead = {1'b1, lineRate};
      ADDR_SOFT_STATION: regRead = {1'b1, 8'h00, softStation};
      ADDR_SAVE: regRead = {1'b1, 8'h00, saveControl};
      ADDR_CONTROL: regRead = {1'b1, controlWord};
      ADDR_STATUS: regRead = {1'b1, deviceStatus};
      default: regRead = 17'h00000;
    endcase
  endfunction

  // Whether a value may be written at an address
  function automatic logic writeOk(input logic [15:0] a, input logic [15:0] d);
    case (a)
      ADDR_STATION, ADDR_SOFT_STATION: writeOk = d >= STATION_MIN && d <= STATION_MAX;
      ADDR_LINE_RATE: writeOk = d == RATE_9600 || d == RATE_19200
                                || d == RATE_38400 || d == RATE_115200;
      ADDR_SAVE: writeOk = d == SAVE_STORE || d == SAVE_INIT;
      ADDR_CONTROL: writeOk = 1'b1;
      default: writeOk = 1'b0; // Status word is read only
    endcase
  endfunction

  // Two-stage synchronisers for the pins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
      swMeta <= '0;
      swSync <= '0;
    end else begin
      rxMeta <= rxPin;
      rxSync <= rxMeta;
      swMeta <= idSelectSwitches;
      swSync <= swMeta;
    end
  end

  // Settings take effect only at restart or on the initialize action
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      loaded <= 1'b0;
      startCnt <= 2'h0;
      initPending <= 1'b0;
      activeStation <= 7'h01;
      bitCyc <= CYC_19200;
    end else begin
      if (!loaded) begin
        if (startCnt == 2'h3) begin
          loaded <= 1'b1;
          activeStation <= (swSync != '0) ? {1'b0, swSync} : softStation[6:0];
          bitCyc <= bitCycles(lineRate);
        end else begin
          startCnt <= startCnt + 2'h1;
        end
      end else if (initPending && state == S_RX) begin
        loaded <= 1'b0;
        startCnt <= 2'h0;
        initPending <= 1'b0;
      end
      if (wr.en && wr.addr == ADDR_SAVE && wr.data == SAVE_INIT) begin
        initPending <= 1'b1;
      end
    end
  end

  // Character receiver, 8N1, sampled mid-bit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxBusy <= 1'b0;
      rxCnt <= 16'h0000;
      rxBit <= 4'h0;
      rxShift <= 8'h00;
      byteValid <= 1'b0;
      byteErr <= 1'b0;
    end else begin
      byteValid <= 1'b0;
      byteErr <= 1'b0;
      if (!rxBusy) begin
        if (loaded && !rxSync) begin
          rxBusy <= 1'b1;
          rxCnt <= {1'b0, bitCyc[15:1]};
          rxBit <= 4'h0;
        end
      end else if (rxCnt != 16'h0000) begin
        rxCnt <= rxCnt - 16'h0001;
      end else begin
        rxCnt <= bitCyc - 16'h0001;
        rxBit <= rxBit + 4'h1;
        if (rxBit == 4'h0 && rxSync) begin
          rxBusy <= 1'b0; // Start bit was a glitch
        end else if (rxBit == 4'h9) begin
          rxBusy <= 1'b0;
          byteValid <= rxSync;
          byteErr <= !rxSync;
        end else if (rxBit != 4'h0) begin
          rxShift <= {rxSync, rxShift[7:1]};
        end
      end
    end
  end

  // Line silence in half-bit units, gap latched at each start bit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      halfCnt <= 16'h0000;
      gapHalf <= 8'h00;
      lastGap <= 8'h00;
    end else begin
      if (!rxBusy && loaded && !rxSync) begin
        lastGap <= gapHalf;
      end
      if (rxBusy || !loaded) begin
        halfCnt <= 16'h0000;
        gapHalf <= 8'h00;
      end else if (halfCnt >= {1'b0, bitCyc[15:1]} - 16'h0001) begin
        halfCnt <= 16'h0000;
        if (gapHalf != 8'hff) begin
          gapHalf <= gapHalf + 8'h01;
        end
      end else begin
        halfCnt <= halfCnt + 16'h0001;
      end
    end
  end

  assign frameEnd = (rxLen != '0 || rxBad) && !rxBusy && gapHalf >= GAP_END_HALF;

  // Frame length and soundness
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxLen <= '0;
      rxBad <= 1'b0;
    end else if (state == S_PARSE || !loaded) begin
      rxLen <= '0;
      rxBad <= 1'b0;
    end else if (state == S_RX && (byteValid || byteErr)) begin
      if (byteErr || rxLen == FRAME_LAST) begin
        rxBad <= 1'b1;
      end
      if (rxLen != '0 && lastGap > GAP_BREAK_HALF) begin
        rxBad <= 1'b1;
      end
      if (byteValid && rxLen != FRAME_LAST) begin
        rxLen <= rxLen + 1'b1;
      end
    end
  end

  // Frame byte store
  always_ff @(posedge mclk) begin
    if (state == S_RX && byteValid && rxLen != FRAME_LAST) begin
      rxBuf[rxLen] <= rxShift;
    end
  end

  // Receive CRC over the whole frame, residue zero when good
  mrs_crc16 uRxCrc (
    .mclk(mclk),
    .rst_n(rst_n),
    .clear(state == S_PARSE || !loaded),
    .enable(state == S_RX && byteValid),
    .dataByte(rxShift),
    .crc(rxCrc)
  );

  // Word addressing for check, write and reply
  assign curAddr = opAddr + {8'h00, opIdx};
  assign opLast = opIdx == opCount - 8'h01;
  assign wordIn = (opFc == FC_WRITE1) ? {rxBuf[4], rxBuf[5]}
                  : {rxBuf[IW'(7 + 2 * opIdx)], rxBuf[IW'(8 + 2 * opIdx)]};
  assign rdOff = txIdx - 8'h03;
  assign lookAddr = (state == S_TX) ? opAddr + {9'h000, rdOff[7:1]} : curAddr;
  assign lookWord = regRead(lookAddr);

  // Request decode, address check and write sequencing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_LOAD;
      opFc <= 8'h00;
      opAddr <= 16'h0000;
      opCount <= 8'h00;
      opIdx <= 8'h00;
      isErr <= 1'b0;
      errCode <= 8'h00;
    end else begin
      unique case (state)
        S_LOAD: begin
          if (loaded) begin
            state <= S_RX;
          end
        end
        S_RX: begin
          if (!loaded) begin
            state <= S_LOAD;
          end else if (frameEnd) begin
            state <= S_PARSE;
          end
        end
        S_PARSE: begin
          isErr <= 1'b0;
          opIdx <= 8'h00;
          opFc <= rxBuf[1];
          opAddr <= {rxBuf[2], rxBuf[3]};
          opCount <= rxBuf[5];
          if (rxBad || rxLen < IW'(4) || rxCrc != 16'h0000
              || rxBuf[0] != {1'b0, activeStation}) begin
            state <= S_RX;
          end else begin
            state <= S_CHECK;
            case (rxBuf[1])
              FC_READ: begin
                if (rxLen != IW'(8) || rxBuf[4] != 8'h00 || rxBuf[5] == 8'h00
                    || rxBuf[5] > 8'(MAX_READ_REGS)) begin
                  isErr <= 1'b1;
                  errCode <= ERR_DATA;
                  state <= S_TX;
                end
              end
              FC_WRITE1: begin
                opCount <= 8'h01;
                if (rxLen != IW'(8)) begin
                  isErr <= 1'b1;
                  errCode <= ERR_DATA;
                  state <= S_TX;
                end
              end
              FC_WRITEN: begin
                if (rxBuf[4] != 8'h00 || rxBuf[5] == 8'h00
                    || rxBuf[5] > 8'(MAX_WRITE_REGS)
                    || rxBuf[6] != {rxBuf[5][6:0], 1'b0}
                    || 8'(rxLen) != 8'h09 + rxBuf[6]) begin
                  isErr <= 1'b1;
                  errCode <= ERR_DATA;
                  state <= S_TX;
                end
              end
              default: begin
                isErr <= 1'b1;
                errCode <= ERR_FUNCTION;
                state <= S_TX;
              end
            endcase
          end
        end
        S_CHECK: begin
          if (!lookWord[16]) begin
            isErr <= 1'b1;
            errCode <= ERR_ADDRESS;
            state <= S_TX;
          end else if (opFc != FC_READ && !writeOk(curAddr, wordIn)) begin
            isErr <= 1'b1;
            errCode <= ERR_WRITE;
            state <= S_TX;
          end else if (opLast) begin
            opIdx <= 8'h00;
            state <= (opFc == FC_READ) ? S_TX : S_EXEC;
          end else begin
            opIdx <= opIdx + 8'h01;
          end
        end
        S_EXEC: begin
          if (opLast) begin
            state <= S_TX;
          end else begin
            opIdx <= opIdx + 8'h01;
          end
        end
        S_TX: begin
          if (txDone) begin
            state <= S_RX;
          end
        end
      endcase
    end
  end

  // Write port into the holding registers, only after the whole check passed
  always_comb begin
    wr.en = state == S_EXEC;
    wr.addr = curAddr;
    wr.data = wordIn;
  end

  // Holding registers and action pulses
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stationNumber <= STATION_RST;
      lineRate <= LINE_RATE_RST;
      softStation <= SOFT_STATION_RST;
      saveControl <= SAVE_RST;
      controlWord <= CONTROL_RST;
      controlStrobe <= 1'b0;
      storeRequest <= 1'b0;
      initRequest <= 1'b0;
    end else begin
      controlStrobe <= 1'b0;
      storeRequest <= 1'b0;
      initRequest <= 1'b0;
      if (wr.en) begin
        case (wr.addr)
          ADDR_STATION: stationNumber <= wr.data[7:0];
          ADDR_LINE_RATE: lineRate <= wr.data;
          ADDR_SOFT_STATION: softStation <= wr.data[7:0];
          ADDR_SAVE: begin
            saveControl <= wr.data[7:0];
            storeRequest <= wr.data == SAVE_STORE;
            initRequest <= wr.data == SAVE_INIT;
          end
          ADDR_CONTROL: begin
            controlWord <= wr.data;
            controlStrobe <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Reply layout: normal, echo or exception
  assign bodyLen = isErr ? 8'h03 : (opFc == FC_READ) ? 8'h03 + {opCount[6:0], 1'b0} : 8'h06;
  assign totalLen = bodyLen + 8'h02;

  always_comb begin
    if (txIdx == bodyLen) begin
      txByte = txCrc[7:0];
    end else if (txIdx == bodyLen + 8'h01) begin
      txByte = txCrc[15:8];
    end else if (txIdx == 8'h00) begin
      txByte = {1'b0, activeStation};
    end else if (txIdx == 8'h01) begin
      txByte = isErr ? (opFc | EXC_FLAG) : opFc;
    end else if (txIdx == 8'h02) begin
      txByte = isErr ? errCode : (opFc == FC_READ) ? {opCount[6:0], 1'b0} : rxBuf[2];
    end else if (opFc == FC_READ) begin
      txByte = rdOff[0] ? lookWord[7:0] : lookWord[15:8];
    end else begin
      txByte = rxBuf[IW'(txIdx)];
    end
  end

  assign txLoad = state == S_TX && txBits == 4'h0 && txIdx != totalLen;
  assign txDone = txIdx == totalLen && txBits == 4'h0;

  // Transmit CRC over the reply body
  mrs_crc16 uTxCrc (
    .mclk(mclk),
    .rst_n(rst_n),
    .clear(state != S_TX),
    .enable(txLoad && txIdx < bodyLen),
    .dataByte(txByte),
    .crc(txCrc)
  );

  // Character transmitter, next byte loaded as soon as the stop bit ends
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txIdx <= 8'h00;
      txBits <= 4'h0;
      txCnt <= 16'h0000;
      txShift <= 9'h1ff;
      txPin <= 1'b1;
      txEnable <= 1'b0;
    end else begin
      txEnable <= state == S_TX;
      if (state != S_TX) begin
        txIdx <= 8'h00;
      end else if (txLoad) begin
        txIdx <= txIdx + 8'h01;
        txShift <= {1'b1, txByte};
        txPin <= 1'b0;
        txBits <= 4'ha;
        txCnt <= bitCyc - 16'h0001;
      end
      if (txBits != 4'h0) begin
        if (txCnt != 16'h0000) begin
          txCnt <= txCnt - 16'h0001;
        end else begin
          txCnt <= bitCyc - 16'h0001;
          txPin <= txShift[0];
          txShift <= {1'b1, txShift[8:1]};
          txBits <= txBits - 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/mrs_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module mrs_master_model import mrs_pkg::*; (
  output logic rxPin,
  input wire logic mclk,
  input wire logic txPin,
  input wire logic txEnable
);
  int bitCyc = int'(BIT_CYC_19200);
  // Biased bus rests high between frames
  initial rxPin = 1'b1;
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Frame check, reflected, starting from all ones
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction
  // Silence, then the frame back to back except for a 22-bit pause before byte gapAt, check bytes low first
  task automatic send(input logic [7:0] f[$], input int gapAt, input bit badCrc);
    logic [15:0] c;
    logic [9:0] w;
    c = crc(f) ^ {15'h0000, badCrc};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    idle(44 * bitCyc);
    foreach (f[i]) begin
      if (i == gapAt) idle(22 * bitCyc);
      w = {1'b1, f[i], 1'b0};
      for (int k = 0; k < 10; k++) begin
        rxPin = w[k];
        idle(bitCyc);
      end
    end
  endtask
  // Sample each reply bit in its middle until the driver lets go
  task automatic recv(output logic [7:0] r[$]);
    int n;
    logic [7:0] b;
    r = {};
    n = 0;
    while (!txEnable && n < 60 * bitCyc) begin
      @(negedge mclk);
      n++;
    end
    while (txEnable === 1'b1) begin
      n = 0;
      while (txPin && txEnable && n < 20 * bitCyc) begin
        @(negedge mclk);
        n++;
      end
      if (txPin !== 1'b0) break;
      idle(bitCyc / 2);
      for (int k = 0; k < 8; k++) begin
        idle(bitCyc);
        b[k] = txPin;
      end
      idle(bitCyc);
      r.push_back(b);
    end
  endtask
endmodule
`default_nettype wire

//--- testbench/mrs_modbus_slave_port_properties.sv
`timescale 1ns/1ns
`default_nettype none
module mrs_port_checker import mrs_pkg::*; #(
  parameter int MAX_READ_REGS = 125,
  parameter int MAX_WRITE_REGS = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rxPin,
  input wire logic txPin,
  input wire logic txEnable,
  input wire logic [SW_WIDTH-1:0] idSelectSwitches,
  input wire logic [15:0] deviceStatus,
  input wire logic [15:0] controlWord,
  input wire logic controlStrobe,
  input wire logic storeRequest,
  input wire logic initRequest,
  input wire logic [6:0] activeStation
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  tx_idle_high_a:
    assert property (!txEnable |-> txPin) else $error("line not idle high");
  start_on_enable_a:
    assert property ($rose(txEnable) |-> (txEnable && !txPin)[*8]) else $error("no start bit");
  enable_end_a:
    assert property ($fell(txEnable) |-> $past(txPin) && $past(txPin, 8))
    else $error("reply ended without stop bit");
  strobe_pulse_a:
    assert property (controlStrobe |-> !txEnable ##1 !controlStrobe) else $error("bad strobe");
  control_hold_a:
    assert property ($changed(controlWord) |-> controlStrobe) else $error("silent word change");
  save_pulse_a:
    assert property (storeRequest |-> !initRequest && !txEnable ##1 !storeRequest)
    else $error("bad store pulse");
  init_pulse_a:
    assert property (initRequest |-> !storeRequest ##1 !initRequest) else $error("bad init pulse");
  station_range_a:
    assert property (activeStation != 7'h00) else $error("station zero in use");
endmodule
bind mrs_modbus_slave_port mrs_port_checker #(
  .MAX_READ_REGS(MAX_READ_REGS),
  .MAX_WRITE_REGS(MAX_WRITE_REGS)
) checkerInst (.mclk, .rst_n, .rxPin, .txPin, .txEnable, .idSelectSwitches, .deviceStatus,
  .controlWord, .controlStrobe, .storeRequest, .initRequest, .activeStation);
`default_nettype wire

//--- testbench/mrs_modbus_slave_port_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin badCount++; \
  $display("[ERR] %0t got %h expected %h", $time, g, e); end end
module mrs_modbus_slave_port_tb_top import mrs_pkg::*;;
  typedef logic [7:0] mrs_bq_t[$];
  // Slow model clock keeps bit times short: 10 cycles per bit at the fast rate
  localparam int BENCH_FREQ = 1_152_000;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic rxPin, txPin, txEnable, controlStrobe, storeRequest, initRequest;
  logic [SW_WIDTH-1:0] idSelectSwitches = '0;
  logic [15:0] deviceStatus = 16'h0031;
  logic [15:0] controlWord;
  logic [6:0] activeStation;
  logic [7:0] st = 8'h7f;
  mrs_bq_t none, q, e;
  int badCount = 0, testsRun = 0, stores = 0, inits = 0, strobes = 0;
  always #4 mclk = ~mclk;
  // Count the one-cycle request pulses
  always @(posedge mclk) begin
    stores <= stores + int'(storeRequest === 1'b1);
    inits <= inits + int'(initRequest === 1'b1);
    strobes <= strobes + int'(controlStrobe === 1'b1);
  end
  mrs_modbus_slave_port #(.CLK_FREQ(BENCH_FREQ)) DUT (.mclk(mclk), .rst_n(rst_n),
    .rxPin(rxPin), .txPin(txPin),
    .txEnable(txEnable), .idSelectSwitches(idSelectSwitches), .deviceStatus(deviceStatus),
    .controlWord(controlWord), .controlStrobe(controlStrobe), .storeRequest(storeRequest),
    .initRequest(initRequest), .activeStation(activeStation));
  mrs_master_model MST (.rxPin(rxPin), .mclk(mclk), .txPin(txPin), .txEnable(txEnable));
  function automatic mrs_bq_t rq(input logic [7:0] fc, input logic [15:0] a, v);
    return '{st, fc, a[15:8], a[7:0], v[15:8], v[7:0]};
  endfunction
  task automatic xact(input mrs_bq_t q, input mrs_bq_t e, input int gap = -1, input bit bad = 0);
    mrs_bq_t r;
    logic [15:0] c;
    c = MST.crc(e);
    if (e.size() > 0) begin
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    MST.send(q, gap, bad);
    MST.recv(r);
    `CHK(r.size(), e.size())
    foreach (e[i]) if (i < r.size()) `CHK(r[i], e[i])
  endtask
  task automatic rd(input logic [15:0] a, v);
    xact(rq(FC_READ, a, 16'h0001), '{st, FC_READ, 8'h02, v[15:8], v[7:0]});
  endtask
  task automatic wr(input logic [15:0] a, v);
    xact(rq(FC_WRITE1, a, v), rq(FC_WRITE1, a, v));
  endtask
  task automatic er(input logic [7:0] fc, input logic [15:0] a, v, input logic [7:0] code);
    xact(rq(fc, a, v), '{st, fc | EXC_FLAG, code});
  endtask
  task automatic wrapUp;
    if (badCount == 0 && testsRun > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence: settings at the slow rate, then the rest at the fast rate
  initial begin
    MST.bitCyc = BENCH_FREQ / BAUD_19200;
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
    `CHK(activeStation, 7'h7f)
    rd(ADDR_LINE_RATE, LINE_RATE_RST);
    wr(ADDR_LINE_RATE, RATE_115200);
    wr(ADDR_SOFT_STATION, 16'h000a);
    wr(ADDR_SAVE, SAVE_INIT);
    MST.bitCyc = BENCH_FREQ / BAUD_115200;
    st = 8'h0a;
    rd(ADDR_STATUS, deviceStatus);
    rd(ADDR_STATION, 16'h0001);
    er(FC_WRITE1, ADDR_LINE_RATE, 16'h0001, ERR_WRITE);
    `CHK(activeStation, 7'h0a)
    `CHK(inits, 1)
    wr(ADDR_SAVE, SAVE_STORE);
    `CHK(stores, 1)
    wr(ADDR_CONTROL, 16'h000f);
    `CHK(controlWord, 16'h000f)
    q = rq(FC_WRITEN, ADDR_CONTROL, 16'h0001);
    e = q;
    q.push_back(8'h02);
    q.push_back(8'h12);
    q.push_back(8'h34);
    xact(q, e);
    `CHK(controlWord, 16'h1234)
    `CHK(strobes, 2)
    er(8'h07, ADDR_STATUS, 16'h0001, ERR_FUNCTION);
    er(FC_READ, 16'h0001, 16'h0001, ERR_ADDRESS);
    er(FC_READ, ADDR_STATUS, 16'h0000, ERR_DATA);
    er(FC_WRITE1, ADDR_STATUS, 16'h0005, ERR_WRITE);
    er(FC_WRITE1, ADDR_SOFT_STATION, 16'h0000, ERR_WRITE);
    xact(rq(FC_READ, ADDR_STATUS, 16'h0001), none, -1, 1'b1);
    xact(rq(FC_READ, ADDR_STATUS, 16'h0001), none, 3);
    st = 8'h05;
    xact(rq(FC_READ, ADDR_STATUS, 16'h0001), none);
    idSelectSwitches = 6'h03;
    rst_n = 1'b0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
    `CHK(activeStation, 7'h03)
    wrapUp();
  end
  // Watchdog: four slow exchanges and fourteen fast ones take about 90k cycles
  initial begin
    repeat (115_000) @(posedge mclk);
    badCount++;
    wrapUp();
  end
endmodule
`default_nettype wire
